// ===== hdl/ptp_pkg.sv
// package: partition bundle types and constants for the tag propagation block
package ptp_pkg;
  // ----------------------------------------------------------------
  // field widths
  // ----------------------------------------------------------------
  localparam int unsigned PN_W = 16;
  localparam int unsigned MG_W = 8;
  localparam int unsigned SP_W = 2;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned LINES = 16;
  localparam int unsigned IDX_W = 4;
  localparam int unsigned OFS_W = 6;
  localparam int unsigned TAG_W = ADDR_W - IDX_W - OFS_W;
  localparam int unsigned QDEPTH = 4;
  localparam int unsigned QPTR_W = 2;
  localparam int unsigned SET_W = 8;
  localparam int unsigned NPART = 16;
  localparam int unsigned NPART_W = 4;
  localparam int unsigned NSPACE = 4;
  // ----------------------------------------------------------------
  // space encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] SP_SECURE = 2'h0;
  localparam logic [1:0] SP_NONSEC = 2'h1;
  localparam logic [1:0] SP_ROOT = 2'h2;
  localparam logic [1:0] SP_REALM = 2'h3;
  localparam logic [15:0] MAX_PN_NS = 16'h000F;
  localparam logic [15:0] MAX_PN_S = 16'h0007;
  localparam logic [15:0] MAX_PN_RT = 16'h0003;
  localparam logic [15:0] MAX_PN_RL = 16'h0003;
  localparam logic [7:0] SET_RESET = 8'h00;
  localparam logic [QPTR_W:0] QCNT_RESET = 3'h0;

  typedef struct packed {
    logic [SP_W-1:0] space_select;
    logic [PN_W-1:0] partition_number;
    logic [MG_W-1:0] monitor_group;
  } ptp_bundle_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    ptp_bundle_t bundle;
  } ptp_req_t;

  typedef struct packed {
    logic valid;
    logic [TAG_W-1:0] tag;
    ptp_bundle_t bundle;
  } ptp_line_t;
endpackage

// ===== hdl/ptp_router.sv
// module: partition bundle propagation through a caching router
// ----------------------------------------------------------------
// Summary of operation
// - partition number carried and stored at most 16 bits wide
// - monitor group carried and stored at most 8 bits wide
// - numbers 0 up to per-space maximum inclusive are valid
// - this component keeps its own maximum for each space
// - nonsecure and secure maxima reported in two id words
// - terminating mode services requests and forwards no bundle
// - routed requests forward the bundle unchanged bit for bit
// - locally completed requests forward no bundle
// - queued requests keep bundle intact until released
// - allocated cache line stores bundle of allocating request
// - space select is two bits in a four-space region
// - space select received and propagated with every request
// - two-bit space select delivered towards two-space bridges
// - bridge from two-space side drives two-bit space select
// - bundle may be dropped with no partition-aware downstream
// - partition identified by space and number together
// - each resource keeps independent settings per partition
// - monitor may filter counts by monitor group
// - space and number select resource parameters per request
// ----------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module ptp_router
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // configuration, static levels from same domain
  input wire logic i_terminate,
  input wire logic i_no_aware_down,
  input wire logic i_two_space_up,
  input wire logic i_up_nonsecure_space_flag,
  // upstream request
  input wire logic i_up_valid,
  input var ptp_pkg::ptp_req_t i_up_req,
  output logic o_up_ready,
  // local completion
  output logic o_local_done,
  output logic o_local_hit,
  output logic o_range_err,
  output logic [ptp_pkg::SET_W-1:0] o_setting,
  // downstream request
  output logic o_dn_valid,
  output ptp_pkg::ptp_req_t o_dn_req,
  input wire logic i_dn_ready,
  // settings write port
  input wire logic i_set_we,
  input wire logic [ptp_pkg::SP_W-1:0] i_set_space,
  input wire logic [ptp_pkg::NPART_W-1:0] i_set_pn,
  input wire logic [ptp_pkg::SET_W-1:0] i_set_val,
  // monitor filter
  input wire logic [ptp_pkg::SP_W-1:0] i_mon_space,
  input wire logic [ptp_pkg::PN_W-1:0] i_mon_pn,
  input wire logic [ptp_pkg::MG_W-1:0] i_mon_mg,
  input wire logic i_mon_use_mg,
  output logic [15:0] o_mon_count,
  // identification words
  output logic [ptp_pkg::PN_W-1:0] o_feature_id_register,
  output logic [ptp_pkg::PN_W-1:0] o_secure_id_register
);
  // ----------------------------------------------------------------
  // intake: bundle normalisation
  // ----------------------------------------------------------------
  ptp_pkg::ptp_req_t in_req;
  logic [ptp_pkg::PN_W-1:0] max_pn;
  logic in_range;
  logic take;
  always_comb
  begin
    in_req = i_up_req;
    // two-space side carries only a flag; widen it to the 2-bit select
    if (i_two_space_up)
    begin
      in_req.bundle.space_select = i_up_nonsecure_space_flag ?
        ptp_pkg::SP_NONSEC : ptp_pkg::SP_SECURE;
    end
  end
  always_comb
  begin
    case (in_req.bundle.space_select)
      ptp_pkg::SP_SECURE: max_pn = ptp_pkg::MAX_PN_S;
      ptp_pkg::SP_NONSEC: max_pn = ptp_pkg::MAX_PN_NS;
      ptp_pkg::SP_ROOT: max_pn = ptp_pkg::MAX_PN_RT;
      default: max_pn = ptp_pkg::MAX_PN_RL;
    endcase
  end
  // out-of-range numbers are serviced but flagged and given SET_RESET; a constrained choice
  assign in_range = in_req.bundle.partition_number <= max_pn;

  // ----------------------------------------------------------------
  // request queue
  // ----------------------------------------------------------------
  ptp_pkg::ptp_req_t q_mem [ptp_pkg::QDEPTH];
  logic [ptp_pkg::QPTR_W-1:0] wr_ptr_r;
  logic [ptp_pkg::QPTR_W-1:0] rd_ptr_r;
  logic [ptp_pkg::QPTR_W:0] cnt_r;
  logic q_empty;
  logic q_pop;
  ptp_pkg::ptp_req_t head;
  assign q_empty = (cnt_r == ptp_pkg::QCNT_RESET);
  assign take = i_up_valid && o_up_ready;
  assign head = q_mem[rd_ptr_r];
  always_ff @(posedge i_clock)
  begin
    if (take)
    begin
      q_mem[wr_ptr_r] <= in_req;
    end
  end
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= ptp_pkg::QCNT_RESET;
    end
    else
    begin
      if (take)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (q_pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      cnt_r <= cnt_r + {2'h0, take} - {2'h0, q_pop};
    end
  end
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      o_up_ready <= 1'b0;
    else
      o_up_ready <= (cnt_r + {2'h0, take} - {2'h0, q_pop})
        < 3'(ptp_pkg::QDEPTH - 1);
  end

  // ----------------------------------------------------------------
  // cache tags with stored bundle
  // ----------------------------------------------------------------
  ptp_pkg::ptp_line_t lines_r [ptp_pkg::LINES];
  logic [ptp_pkg::IDX_W-1:0] idx;
  logic [ptp_pkg::TAG_W-1:0] tag;
  logic hit;
  assign idx = head.addr[ptp_pkg::OFS_W +: ptp_pkg::IDX_W];
  assign tag = head.addr[ptp_pkg::ADDR_W-1 -: ptp_pkg::TAG_W];
  assign hit = lines_r[idx].valid && (lines_r[idx].tag == tag);

  // stage: head is handled once the output stage is free
  logic out_busy;
  assign out_busy = o_dn_valid && !i_dn_ready;
  assign q_pop = !q_empty && !out_busy;
  // reads that hit or any request in terminating mode stay local
  logic local_c;
  assign local_c = i_terminate || (hit && !head.write);

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      for (int i = 0; i < ptp_pkg::LINES; i++)
        lines_r[i] <= '0;
    end
    else if (q_pop && !hit && !i_terminate)
    begin
      lines_r[idx].valid <= 1'b1;
      lines_r[idx].tag <= tag;
      lines_r[idx].bundle <= head.bundle;
    end
  end

  // ----------------------------------------------------------------
  // settings table per space and partition
  // ----------------------------------------------------------------
  logic [ptp_pkg::SET_W-1:0] settings_r [ptp_pkg::NSPACE][ptp_pkg::NPART];
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      for (int s = 0; s < ptp_pkg::NSPACE; s++)
        for (int p = 0; p < ptp_pkg::NPART; p++)
          settings_r[s][p] <= ptp_pkg::SET_RESET;
    end
    else if (i_set_we)
    begin
      settings_r[i_set_space][i_set_pn] <= i_set_val;
    end
  end

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  logic head_range;
  logic [ptp_pkg::PN_W-1:0] head_max;
  always_comb
  begin
    case (head.bundle.space_select)
      ptp_pkg::SP_SECURE: head_max = ptp_pkg::MAX_PN_S;
      ptp_pkg::SP_NONSEC: head_max = ptp_pkg::MAX_PN_NS;
      ptp_pkg::SP_ROOT: head_max = ptp_pkg::MAX_PN_RT;
      default: head_max = ptp_pkg::MAX_PN_RL;
    endcase
  end
  assign head_range = head.bundle.partition_number <= head_max;

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_dn_valid <= 1'b0;
      o_dn_req <= '0;
    end
    else if (!out_busy)
    begin
      o_dn_valid <= q_pop && !local_c;
      o_dn_req.addr <= head.addr;
      o_dn_req.write <= head.write;
      // bundle dropped when nobody downstream uses it
      if (i_no_aware_down)
        o_dn_req.bundle <= '0;
      else
        o_dn_req.bundle <= head.bundle;
    end
  end
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_local_done <= 1'b0;
      o_local_hit <= 1'b0;
      o_range_err <= 1'b0;
      o_setting <= ptp_pkg::SET_RESET;
    end
    else
    begin
      o_local_done <= q_pop && local_c;
      o_local_hit <= q_pop && hit;
      o_range_err <= q_pop && !head_range;
      // an out-of-range number gets SET_RESET so it cannot alias another partition
      o_setting <= head_range ? settings_r[head.bundle.space_select]
        [head.bundle.partition_number[ptp_pkg::NPART_W-1:0]]
        : ptp_pkg::SET_RESET;
    end
  end

  // ----------------------------------------------------------------
  // usage monitor with optional group filter
  // ----------------------------------------------------------------
  logic mon_match;
  assign mon_match = q_pop && head.bundle.space_select == i_mon_space
    && head.bundle.partition_number == i_mon_pn
    && (!i_mon_use_mg || head.bundle.monitor_group == i_mon_mg);
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      o_mon_count <= 16'h0000;
    else if (mon_match)
      o_mon_count <= o_mon_count + 16'h0001;
  end

  // ----------------------------------------------------------------
  // identification
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_feature_id_register <= 16'h0000;
      o_secure_id_register <= 16'h0000;
    end
    else
    begin
      o_feature_id_register <= ptp_pkg::MAX_PN_NS;
      o_secure_id_register <= ptp_pkg::MAX_PN_S;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_FORWARD_EXACT: assert property (@(posedge i_clock) disable iff (i_srst)
    (q_pop && !local_c && !i_no_aware_down && !out_busy) |=>
    (o_dn_valid && o_dn_req.bundle == $past(head.bundle)))
    else $error("routed bundle altered");
  AST_TERMINATE: assert property (@(posedge i_clock) disable iff (i_srst)
    $past(i_terminate) && $past(!out_busy) |-> !o_dn_valid)
    else $error("terminating mode forwarded a request");
  AST_LOCAL_NO_FWD: assert property (@(posedge i_clock) disable iff (i_srst)
    o_local_done |-> !o_dn_valid)
    else $error("local completion also forwarded");
  sequence s_alloc;
    q_pop && !hit && !i_terminate;
  endsequence
  AST_LINE_TAG: assert property (@(posedge i_clock) disable iff (i_srst)
    s_alloc |=>
    lines_r[$past(idx)].bundle == $past(head.bundle))
    else $error("line bundle not stored");
  AST_HOLD_STALL: assert property (@(posedge i_clock) disable iff (i_srst)
    out_busy |=> $stable(o_dn_req) && o_dn_valid)
    else $error("stalled request changed");
  AST_WIDEN: assert property (@(posedge i_clock) disable iff (i_srst)
    (take && i_two_space_up && i_up_nonsecure_space_flag && q_empty)
    |=> head.bundle.space_select == ptp_pkg::SP_NONSEC)
    else $error("space select not driven from flag");
  AST_MON: assert property (@(posedge i_clock) disable iff (i_srst)
    mon_match |=> o_mon_count == $past(o_mon_count) + 16'h0001)
    else $error("monitor missed a match");
  AST_DROP: assert property (@(posedge i_clock) disable iff (i_srst)
    (!out_busy && i_no_aware_down) |=> o_dn_req.bundle == '0)
    else $error("bundle not dropped");
  AST_ID: assert property (@(posedge i_clock) disable iff (i_srst)
    !$past(i_srst) |-> o_secure_id_register == ptp_pkg::MAX_PN_S)
    else $error("secure id wrong");
  // intake and head range checks must agree, or queueing bent a field
  sequence s_enq_empty;
    take && q_empty;
  endsequence
  AST_KEEP_BUNDLE: assert property (@(posedge i_clock) disable iff (i_srst)
    s_enq_empty |=>
    head == $past(in_req))
    else $error("queued request altered");
  AST_INTAKE_RANGE: assert property (@(posedge i_clock) disable iff (i_srst)
    s_enq_empty |=>
    head_range == $past(in_range))
    else $error("range check differs after queueing");
  AST_RANGE_FLAG: assert property (@(posedge i_clock) disable iff (i_srst)
    (q_pop && !head_range) |=>
    (o_range_err && o_setting == ptp_pkg::SET_RESET))
    else $error("out of range number not flagged");
  AST_LOCAL_READ: assert property (@(posedge i_clock) disable iff (i_srst)
    (q_pop && hit && !head.write) |=>
    (o_local_done && o_local_hit && !o_dn_valid))
    else $error("read hit not completed locally");
  AST_NO_OVERRUN: assert property (@(posedge i_clock) disable iff (i_srst)
    take |->
    cnt_r < 3'(ptp_pkg::QDEPTH))
    else $error("request taken into a full queue");
endmodule // ptp_router
`default_nettype wire

// ===== verification/ptp_dn_model.sv
// model: downstream completer that accepts forwarded requests
`timescale 1ns/1ns
`default_nettype none
module ptp_dn_model
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // pacing control
  input wire logic i_stall,
  // request acceptance
  output logic o_dn_ready
);
  logic [1:0] gap_r;
  // ----------------------------------------------------------------
  // acceptance pacing
  // ----------------------------------------------------------------
  // stall mode takes one in four cycles so requests sit queued
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      gap_r <= 2'h0;
      o_dn_ready <= 1'b0;
    end
    else
    begin
      gap_r <= gap_r + 2'h1;
      o_dn_ready <= !i_stall || (gap_r == 2'h2);
    end
  end
endmodule // ptp_dn_model
`default_nettype wire

// ===== verification/tb_partition_tag_propagation.sv
// testbench: partition bundle propagation through the caching router
`timescale 1ns/1ns
`default_nettype none
module tb_partition_tag_propagation;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  logic term = 1'b0, noaw = 1'b0, two = 1'b0, nsf = 1'b0, stall = 1'b0;
  logic up_valid = 1'b0, set_we = 1'b0, mon_use = 1'b0;
  ptp_pkg::ptp_req_t up_req = '0;
  logic [1:0] set_sp = 2'h0, mon_sp = 2'h0;
  logic [3:0] set_pn = 4'h0;
  logic [7:0] set_val = 8'h00, mon_mg = 8'h00;
  logic [15:0] mon_pn = 16'h0000;
  logic up_ready, l_done, l_hit, r_err, dn_valid, dn_ready, held;
  logic [7:0] setting;
  logic [15:0] mon_cnt, id_ns, id_s, c0;
  ptp_pkg::ptp_req_t dn_req;
  logic [69:0] ev_q[$];
  logic [69:0] ev;
  int err_total = 0;
  int total_checks = 0;

  ptp_router uut (.i_clock(i_clock), .i_srst(i_srst), .i_terminate(term),
    .i_no_aware_down(noaw), .i_two_space_up(two),
    .i_up_nonsecure_space_flag(nsf), .i_up_valid(up_valid),
    .i_up_req(up_req), .o_up_ready(up_ready), .o_local_done(l_done),
    .o_local_hit(l_hit), .o_range_err(r_err), .o_setting(setting),
    .o_dn_valid(dn_valid), .o_dn_req(dn_req), .i_dn_ready(dn_ready),
    .i_set_we(set_we), .i_set_space(set_sp), .i_set_pn(set_pn),
    .i_set_val(set_val), .i_mon_space(mon_sp), .i_mon_pn(mon_pn),
    .i_mon_mg(mon_mg), .i_mon_use_mg(mon_use), .o_mon_count(mon_cnt),
    .o_feature_id_register(id_ns), .o_secure_id_register(id_s));
  ptp_dn_model dn (.i_clock(i_clock), .i_srst(i_srst), .i_stall(stall),
    .o_dn_ready(dn_ready));

  initial
  begin
    forever #4 i_clock = ~i_clock;
  end
  // ----------------------------------------------------------------
  // outcome recorder: one entry per completion or new forward
  // ----------------------------------------------------------------
  always @(posedge i_clock)
  begin
    if (i_srst)
      held = 1'b0;
    else
    begin
      if (l_done || (dn_valid && !held))
        ev_q.push_back({dn_valid && !l_done, l_hit, r_err, setting, dn_req});
      held = dn_valid && !dn_ready;
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic ptp_pkg::ptp_req_t mk(input logic [31:0] a,
    input logic w, input logic [1:0] sp, input logic [15:0] pn,
    input logic [7:0] mg);
    mk = {a, w, sp, pn, mg};
  endfunction
  // requester attaches a full bundle to every request
  task automatic send(input ptp_pkg::ptp_req_t r);
    @(negedge i_clock);
    up_valid = 1'b1;
    up_req = r;
    for (int n = 0; n < 100; n++)
    begin
      if (up_ready === 1'b1)
      begin
        @(posedge i_clock);
        return;
      end
      @(negedge i_clock);
    end
    err_total++;
    finish_test();
  endtask
  task automatic wait_ev(input int n);
    @(negedge i_clock);
    up_valid = 1'b0;
    for (int k = 0; k < 300; k++)
    begin
      if (ev_q.size() >= n)
        return;
      @(negedge i_clock);
    end
    err_total++;
    finish_test();
  endtask
  task automatic one(input ptp_pkg::ptp_req_t r);
    send(r);
    wait_ev(1);
    ev = ev_q.pop_front();
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_ids();
    chk(64'(id_ns), 64'(ptp_pkg::MAX_PN_NS));
    chk(64'(id_s), 64'(ptp_pkg::MAX_PN_S));
    chk(64'(up_ready), 64'h1);
  endtask
  // all four spaces at their top number, back to back under stall
  task automatic s_forward();
    logic [15:0] mx[4];
    mx = '{ptp_pkg::MAX_PN_S, ptp_pkg::MAX_PN_NS, ptp_pkg::MAX_PN_RT,
      ptp_pkg::MAX_PN_RL};
    stall = 1'b1;
    for (int i = 0; i < 4; i++)
      send(mk(32'h1000 + 32'(i) * 32'h40, 1'b1, 2'(i), mx[i], 8'hA0 + 8'(i)));
    wait_ev(4);
    stall = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      ev = ev_q.pop_front();
      chk(64'(ev[58:0]), 64'(mk(32'h1000 + 32'(i) * 32'h40, 1'b1, 2'(i),
        mx[i], 8'hA0 + 8'(i))));
      chk(64'({ev[69], ev[67]}), 64'h2);
    end
  endtask
  task automatic s_cache();
    one(mk(32'h0000_2080, 1'b1, 2'h1, 16'h0002, 8'h03));
    one(mk(32'h0000_2080, 1'b0, 2'h1, 16'h0002, 8'h03));
    chk(64'(ev[69:68]), 64'h1);
  endtask
  // out of range number still handled, flagged, setting zero
  task automatic s_range();
    one(mk(32'h3000, 1'b1, ptp_pkg::SP_SECURE, 16'h0008, 8'h01));
    chk(64'({ev[69], ev[67:59]}), 64'h300);
  endtask
  task automatic s_settings();
    for (int s = 0; s < 2; s++)
    begin
      @(negedge i_clock);
      set_we = 1'b1;
      set_sp = 2'(s);
      set_pn = 4'h5;
      set_val = s ? 8'hA5 : 8'h5A;
    end
    @(negedge i_clock);
    set_we = 1'b0;
    one(mk(32'h4000, 1'b1, 2'h0, 16'h0005, 8'h00));
    chk(64'(ev[66:59]), 64'h5A);
    one(mk(32'h4040, 1'b1, 2'h1, 16'h0005, 8'h00));
    chk(64'(ev[66:59]), 64'hA5);
  endtask
  task automatic s_modes();
    term = 1'b1;
    one(mk(32'h5000, 1'b1, 2'h1, 16'h0001, 8'h02));
    chk(64'(ev[69]), 64'h0);
    term = 1'b0;
    noaw = 1'b1;
    one(mk(32'h5040, 1'b1, 2'h2, 16'h0003, 8'h77));
    chk(64'(ev[58:0]), 64'(mk(32'h5040, 1'b1, 2'h0, 16'h0, 8'h0)));
    noaw = 1'b0;
    two = 1'b1;
    for (int f = 0; f < 2; f++)
    begin
      nsf = 1'(f);
      // default bundle from a requester without partition support
      one(mk(32'h6000 + 32'(f) * 32'h40, 1'b1, 2'h3, 16'h0, 8'h0));
      chk(64'(ev[25:24]), 64'(f));
    end
    two = 1'b0;
  endtask
  task automatic s_monitor();
    mon_sp = 2'h1;
    mon_pn = 16'h0004;
    mon_mg = 8'h09;
    mon_use = 1'b1;
    @(negedge i_clock);
    c0 = mon_cnt;
    one(mk(32'h7000, 1'b1, 2'h1, 16'h0004, 8'h09));
    one(mk(32'h7040, 1'b1, 2'h1, 16'h0004, 8'h08));
    one(mk(32'h7080, 1'b1, 2'h0, 16'h0004, 8'h09));
    chk(64'(mon_cnt), 64'(c0 + 16'h1));
    mon_use = 1'b0;
    one(mk(32'h70C0, 1'b1, 2'h1, 16'h0004, 8'h08));
    chk(64'(mon_cnt), 64'(c0 + 16'h2));
  endtask

  initial
  begin
    repeat (12) @(negedge i_clock);
    i_srst = 1'b0;
    repeat (2) @(negedge i_clock);
    s_ids();
    s_forward();
    s_cache();
    s_range();
    s_settings();
    s_modes();
    s_monitor();
    finish_test();
  end
endmodule // tb_partition_tag_propagation
`default_nettype wire
